// ==== logic/dpsb_sram.sv ====
`timescale 1ns/1ps

// How it works
// - 256 bits, as 32x8 or 64x4.
// - Read and write ports work independently.
// - Six-bit addresses select 64 nibbles.
// - Byte mode ignores the address MSB.
// - Own port clocks, each polarity selectable.
// - Eight-bit data in and out; nibble uses four.
module dpsb_sram
#(
   parameter int ADDR_W = dpsb_pkg::DPSB_ADDR_W,
   parameter int DATA_W = dpsb_pkg::DPSB_DATA_W
)
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic CE_I,
   input wire logic BYTE_MODE_I,
   input wire logic WRITE_CLK_I,
   input wire logic WRITE_CLK_POL_I,
   input wire logic WRITE_EN_I,
   input wire logic [dpsb_pkg::DPSB_ADDR_W-1:0] WRITE_ADDR_I,
   input wire logic [dpsb_pkg::DPSB_DATA_W-1:0] WRITE_DATA_IN_I,
   input wire logic READ_CLK_I,
   input wire logic READ_CLK_POL_I,
   input wire logic [dpsb_pkg::DPSB_ADDR_W-1:0] READ_ADDR_I,
   output logic [dpsb_pkg::DPSB_DATA_W-1:0] READ_DATA_O
);
   import dpsb_pkg::*;

   localparam int NW = DPSB_NIB_W;

   // ----------------------------------------------------------------------
   // Storage and port clock detection.
   // ----------------------------------------------------------------------

   logic [NW-1:0] mem [DPSB_NIB_DEPTH];
   logic write_go;
   logic read_go;
   logic [ADDR_W-1:0] write_lo;
   logic [ADDR_W-1:0] read_lo;

   dpsb_edge_if wr_if ();
   dpsb_edge_if rd_if ();

   // Each port clock pin is paired with its own polarity choice.
   assign wr_if.pin = WRITE_CLK_I;
   assign wr_if.pol_high = WRITE_CLK_POL_I;
   assign rd_if.pin = READ_CLK_I;
   assign rd_if.pol_high = READ_CLK_POL_I;

   dpsb_edge_det u_wr_edge
   (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .port(wr_if.det)
   );

   dpsb_edge_det u_rd_edge
   (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .port(rd_if.det)
   );

   // Maps a port address to the index of its lower nibble.
   function automatic logic [ADDR_W-1:0] lo_index
   (
      input logic [ADDR_W-1:0] addr,
      input logic byte_mode
   );
      if (byte_mode)
         lo_index = {addr[DPSB_BYTE_ADDR_W-1:0], 1'b0};
      else
         lo_index = addr;
   endfunction : lo_index

   // Strobes and addresses of the two independent ports.
   assign write_go = wr_if.strobe && WRITE_EN_I && RST_N_I;
   assign read_go = rd_if.strobe && RST_N_I;
   assign write_lo = lo_index(WRITE_ADDR_I, BYTE_MODE_I);
   assign read_lo = lo_index(READ_ADDR_I, BYTE_MODE_I);

   // ----------------------------------------------------------------------
   // Write port.
   // ----------------------------------------------------------------------

   // Stores a byte into two nibbles, or one nibble; contents survive reset.
   always_ff @(posedge CLK_I)
   begin
      if (write_go)
      begin
         mem[write_lo] <= WRITE_DATA_IN_I[NW-1:0];
         if (BYTE_MODE_I)
            mem[write_lo | 6'h01] <= WRITE_DATA_IN_I[DATA_W-1:NW];
      end
   end

   // ----------------------------------------------------------------------
   // Read port.
   // ----------------------------------------------------------------------

   // Registers the addressed word; nibble mode zeroes the upper bits.
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
         READ_DATA_O <= DPSB_RD_RESET;
      else if (read_go)
      begin
         if (BYTE_MODE_I)
            READ_DATA_O <= {mem[read_lo | 6'h01], mem[read_lo]};
         else
            READ_DATA_O <= {4'h0, mem[read_lo]};
      end
   end

   // ----------------------------------------------------------------------
   // Checks.
   // ----------------------------------------------------------------------

   logic last_valid;
   logic last_byte;
   logic [ADDR_W-1:0] last_addr;
   logic [DATA_W-1:0] last_data;
   logic addr_hit;

   // Remembers the most recent write for read-back checks.
   always_ff @(posedge CLK_I)
   begin
      if (!RST_N_I)
         last_valid <= 1'b0;
      else if (write_go)
      begin
         last_valid <= 1'b1;
         last_byte <= BYTE_MODE_I;
         last_addr <= WRITE_ADDR_I;
         last_data <= WRITE_DATA_IN_I;
      end
   end

   // A read hits the last write when the compared address bits agree.
   assign addr_hit = last_valid && (last_byte == BYTE_MODE_I) &&
      (BYTE_MODE_I ?
       (READ_ADDR_I[4:0] == last_addr[4:0]) : (READ_ADDR_I == last_addr));

   // All checks run on the system clock and sleep through reset. The
   // reset check overrides the default disable so that it stays awake.
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   // A byte read that does not race a write returns the last byte written.
   a_byte_readback: assert property (
      read_go && !write_go && addr_hit && BYTE_MODE_I
      |=> READ_DATA_O == $past(last_data))
      else $error("Byte read did not return the last written byte.");

   // The same holds when the read address differs only in its top bit.
   a_msb_ignored: assert property (
      read_go && !write_go && addr_hit && BYTE_MODE_I &&
      (READ_ADDR_I[5] != last_addr[5]) |=> READ_DATA_O == $past(last_data))
      else $error("Byte mode read depended on the address MSB.");

   // A nibble read returns the nibble last written there, upper bits clear.
   a_nibble_readback: assert property (
      read_go && !write_go && addr_hit && !BYTE_MODE_I
      |=> READ_DATA_O == {4'h0, $past(last_data[3:0])})
      else $error("Nibble read did not return the last written nibble.");

   // Every nibble mode read drives zeroes on the unused upper bits.
   a_nibble_upper: assert property (
      read_go && !BYTE_MODE_I
      |=> READ_DATA_O[7:4] == 4'h0)
      else $error("Upper read bits not zero in nibble mode.");

   // Without an active read edge the read data holds its value.
   a_read_hold: assert property (
      !read_go
      |=> $stable(READ_DATA_O))
      else $error("Read data changed without an active read edge.");

   // A write alone never reaches the read output.
   a_write_no_read: assert property (
      write_go && !read_go
      |=> READ_DATA_O == $past(READ_DATA_O))
      else $error("A write disturbed the read output.");

   // A low clock enable freezes the read data and both edge detectors.
   a_clock_freeze: assert property (
      !CE_I |=> $stable(READ_DATA_O) &&
      $stable(u_wr_edge.prev) && $stable(u_rd_edge.prev))
      else $error("State moved while the clock enable was low.");

   // Reset loads the idle read value at the first edge it is seen.
   a_read_reset: assert property (
      disable iff (1'b0)
      !RST_N_I |=> READ_DATA_O == DPSB_RD_RESET)
      else $error("Read data not cleared by reset.");

   // A nibble write lands in the addressed nibble.
   a_nibble_store: assert property (
      write_go && !BYTE_MODE_I
      |=> mem[$past(write_lo)] == $past(WRITE_DATA_IN_I[NW-1:0]))
      else $error("Nibble write did not land at its address.");

   // A byte write fills an even nibble and the odd one above it.
   a_byte_store: assert property (
      write_go && BYTE_MODE_I |=>
      {mem[$past(write_lo) | 6'h01], mem[$past(write_lo)]} ==
      $past(WRITE_DATA_IN_I))
      else $error("Byte write did not land in its nibble pair.");

   // Main scenarios that the bench is expected to reach.
   c_byte_write: cover property (write_go && BYTE_MODE_I);
   c_nibble_read: cover property (read_go && !BYTE_MODE_I && addr_hit);
   c_both_ports: cover property (read_go && write_go);
   c_falling_read: cover property (read_go && !READ_CLK_POL_I);

endmodule : dpsb_sram

// ==== logic/dpsb_pkg.sv ====
package dpsb_pkg;

   // ----------------------------------------------------------------------
   // Geometry of the memory block.
   // ----------------------------------------------------------------------
   localparam int DPSB_ADDR_W = 6;
   localparam int DPSB_DATA_W = 8;
   localparam int DPSB_NIB_W = 4;
   localparam int DPSB_BYTE_ADDR_W = 5;
   localparam int DPSB_NIB_DEPTH = 64;
   localparam logic [7:0] DPSB_RD_RESET = 8'h00;

endpackage : dpsb_pkg

// ==== logic/dpsb_edge_if.sv ====
`timescale 1ns/1ps

// Carries one port clock pin, its polarity choice and the edge strobe.
interface dpsb_edge_if;
   logic pin;
   logic pol_high;
   logic strobe;

   modport det
   (
      input pin,
      input pol_high,
      output strobe
   );

   modport user
   (
      output pin,
      output pol_high,
      input strobe
   );
endinterface : dpsb_edge_if

// ==== logic/dpsb_edge_det.sv ====
`timescale 1ns/1ps

module dpsb_edge_det
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   dpsb_edge_if.det port
);

   logic prev;

   // -------------------------------------------------------------------
   // Edge detection.
   // -------------------------------------------------------------------

   // Keeps the pin value seen at the previous enabled clock edge.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         prev <= 1'b0;
      else if (ce_i)
         prev <= port.pin;
   end

   // Picks the rising or the falling transition as the active edge.
   assign port.strobe = ce_i &&
      (port.pol_high ? (port.pin && !prev) : (!port.pin && prev));

   // A strobe only ever follows a change of the pin to the active level.
   a_edge_polarity: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      port.strobe |-> (port.pin == port.pol_high) && (prev != port.pin))
      else $error("Strobe raised on an edge of the wrong polarity.");

endmodule : dpsb_edge_det

// ==== testbench/dpsb_port_user.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// User logic that gives one port clock pulse per request.
// ----------------------------------------------------------------
module dpsb_port_user
(
   input wire logic clk_i,
   input wire logic pol_i,
   input wire logic req_i,
   output logic pin_o
);
   logic [2:0] cnt = 3'h0;

   // Three cycles active and three idle, so each request is one edge.
   // The same pin may clock several cascaded blocks at once.
   always_ff @(posedge clk_i)
   begin
      if (req_i)
         cnt <= 3'h6;
      else if (cnt != 3'h0)
         cnt <= cnt - 3'h1;
   end

   // The pin rests at the inactive level of the chosen polarity.
   assign pin_o = (cnt > 3'h3) ? pol_i : ~pol_i;
endmodule : dpsb_port_user

// ==== testbench/dpsb_sram_tb.sv ====
`timescale 1ns/1ps

module dpsb_sram_tb;
   import dpsb_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic bm = 1'b0;
   logic wpol = 1'b1;
   logic rpol = 1'b1;
   logic wen = 1'b1;
   logic wreq = 1'b0;
   logic rreq = 1'b0;
   logic wpin;
   logic rpin;
   logic [5:0] wa = 6'h00;
   logic [5:0] ra = 6'h00;
   logic [7:0] wd = 8'h00;
   logic [7:0] rd;
   int bad_count = 0;
   int num_checks = 0;

   dpsb_port_user wp_u (.clk_i(clk), .pol_i(wpol), .req_i(wreq),
      .pin_o(wpin));
   dpsb_port_user rp_u (.clk_i(clk), .pol_i(rpol), .req_i(rreq),
      .pin_o(rpin));
   dpsb_sram dut_u (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
      .BYTE_MODE_I(bm), .WRITE_CLK_I(wpin), .WRITE_CLK_POL_I(wpol),
      .WRITE_EN_I(wen), .WRITE_ADDR_I(wa), .WRITE_DATA_IN_I(wd),
      .READ_CLK_I(rpin), .READ_CLK_POL_I(rpol), .READ_ADDR_I(ra),
      .READ_DATA_O(rd));

   // ----------------------------------------------------------------
   // Clock, shared tasks and scenarios.
   // ----------------------------------------------------------------
   initial
   begin
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [7:0] exp);
      num_checks++;
      if (rd !== exp)
      begin
         $display("Error READ_DATA_O expected %h seen %h", exp, rd);
         bad_count++;
      end
   endtask : chk

   // Pulses the chosen port pins once and lets the edges settle.
   task automatic go(input logic w, input logic r);
      @(posedge clk);
      #1;
      wreq = w;
      rreq = r;
      @(posedge clk);
      #1;
      wreq = 1'b0;
      rreq = 1'b0;
      repeat (8) @(posedge clk);
      #1;
   endtask : go

   // Fills all 64 nibbles with junk above bit 3, then reads them back.
   task automatic t_nibble();
      for (int i = 0; i < 64; i++)
      begin
         wa = 6'(i);
         wd = {4'hf, 4'(i * 3 + 1)};
         go(1'b1, 1'b0);
      end
      for (int i = 0; i < 64; i++)
      begin
         ra = 6'(i);
         go(1'b0, 1'b1);
         chk({4'h0, 4'(i * 3 + 1)});
      end
   endtask : t_nibble

   // Byte reads pair nibbles; the address top bit is ignored.
   task automatic t_byte();
      bm = 1'b1;
      ra = 6'h20;
      go(1'b0, 1'b1);
      chk(8'h41);
      wa = 6'h25;
      wd = 8'h5a;
      go(1'b1, 1'b0);
      ra = 6'h05;
      go(1'b0, 1'b1);
      chk(8'h5a);
      bm = 1'b0;
      ra = 6'h0b;
      go(1'b0, 1'b1);
      chk(8'h05);
   endtask : t_byte

   // Read and write at once, then writes that must be refused.
   task automatic t_dual();
      bm = 1'b1;
      wa = 6'h01;
      wd = 8'hc3;
      ra = 6'h01;
      go(1'b1, 1'b1);
      chk(8'ha7);
      ra = 6'h01;
      go(1'b0, 1'b1);
      chk(8'hc3);
      wen = 1'b0;
      wd = 8'h99;
      go(1'b1, 1'b0);
      wen = 1'b1;
      ce = 1'b0;
      go(1'b1, 1'b0);
      ce = 1'b1;
      go(1'b0, 1'b1);
      chk(8'hc3);
   endtask : t_dual

   // Both ports work on falling edges.
   task automatic t_pol();
      wpol = 1'b0;
      rpol = 1'b0;
      wa = 6'h02;
      wd = 8'h3c;
      go(1'b0, 1'b0);
      go(1'b1, 1'b0);
      ra = 6'h02;
      go(1'b0, 1'b1);
      chk(8'h3c);
   endtask : t_pol

   // A reset in mid-run clears the read data but keeps the memory.
   task automatic t_reset();
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(DPSB_RD_RESET);
      rst_n = 1'b1;
      ra = 6'h02;
      go(1'b0, 1'b1);
      chk(8'h3c);
   endtask : t_reset

   task automatic print_verdict();
      if (bad_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict

   // Main sequence after four cycles of reset.
   initial
   begin
      repeat (4) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(DPSB_RD_RESET);
      t_nibble();
      t_byte();
      t_dual();
      t_pol();
      t_reset();
      print_verdict();
   end

   // Watchdog well beyond the expected run of about 1400 cycles.
   initial
   begin
      repeat (5000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
endmodule : dpsb_sram_tb
